// ==== phy_ident_and_quick_status_tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, a); end end
module phy_ident_and_quick_status_tb;
   import piqs_pkg::*;
   localparam logic [21:0] OUI = 22'h2C5A93; // arbitrary value
   localparam logic [5:0] MDL = 6'h2B; // arbitrary value
   localparam logic [3:0] REV = 4'h9; // arbitrary value
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr_qs = 1'b0, i_link_ok = 1'b0, o_rd_valid;
   logic i_full_duplex = 1'b0, i_speed_100 = 1'b0, i_pause_ok = 1'b0, i_rd_id1, i_rd_id2, i_rd_qs;
   logic [1:0] op = 2'h0; // host request
   logic [2:0] i_an_state = 3'h0;
   logic [3:0] ev = 4'h0; // rx, carrier, fault, unlock
   logic [15:0] i_wr_data = 16'h0000, o_rd_data, st;
   int bad_count = 0, num_checks = 0, seed = 32'h00A5D95E, hi = 0, lo = 0, stk = 0, lnk = 0;
   always #50 i_clk = ~i_clk;
   piqs_host host (.i_op(op), .o_rd_id1(i_rd_id1), .o_rd_id2(i_rd_id2), .o_rd_qs(i_rd_qs));
   piqs_top #(.P_OUI(OUI), .P_MODEL(MDL), .P_REV(REV)) dut (.i_clk, .i_sys_rst, .i_rd_id1, .i_rd_id2,
      .i_rd_qs, .i_wr_qs, .i_wr_data, .i_an_state, .i_full_duplex, .i_speed_100, .i_pause_ok, .i_link_ok,
      .i_unlock_jabber(ev[0]), .i_remote_fault(ev[1]), .i_false_carrier(ev[2]), .i_rx_error(ev[3]),
      .o_rd_data, .o_rd_valid);
   // read: request for one edge, answer just after
   task automatic rd(input logic [1:0] o, input logic [15:0] e, input string n);
      op <= o;
      @(posedge i_clk);
      op <= 2'h0;
      @(negedge i_clk);
      `CHK("valid", 1'b1, o_rd_valid)
      `CHK(n, e, o_rd_data)
      @(posedge i_clk);
   endtask : rd
   // status answer against the model; model then clears and restarts
   task automatic qchk();
      logic [15:0] e; // modelled word
      e = {stk[3:0], lnk[0], i_pause_ok, i_speed_100, i_full_duplex, 2'h0, lo[2:0], hi[2:0]};
      `CHK("qs valid", 1'b1, o_rd_valid)
      `CHK("qs", e, o_rd_data)
      stk = 0;
      lnk = i_link_ok;
      hi = i_an_state;
      lo = i_an_state;
   endtask : qchk
   // status read, a second one on the very next edge when b2b is set
   task automatic rq(input bit b2b);
      op <= 2'h3;
      @(posedge i_clk);
      if (!b2b) op <= 2'h0;
      @(negedge i_clk);
      qchk();
      if (b2b) begin
         @(posedge i_clk);
         op <= 2'h0;
         @(negedge i_clk);
         qchk();
      end
      @(posedge i_clk);
   endtask : rq
   // new state, held past the synchroniser
   task automatic go(input logic [2:0] s);
      @(posedge i_clk);
      i_an_state <= s;
      hi = s > hi ? s : hi;
      lo = s < lo ? s : lo;
      repeat (5) @(posedge i_clk);
   endtask : go
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize
   // watchdog: run needs under 400 cycles
   initial begin
      repeat (3000) @(posedge i_clk);
      bad_count++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (3) @(posedge i_clk);
      rd(2'h1, OUI[21:6], "id1");
      rd(2'h2, {OUI[5:0], MDL, REV}, "id2");
      rq(1'b0);
      i_link_ok <= 1'b1;
      $display("test ident done");
      // random levels, events, link drops, states
      repeat (10) begin
         @(posedge i_clk);
         st = 16'($random(seed));
         {i_pause_ok, i_speed_100, i_full_duplex} <= st[2:0];
         i_wr_qs <= 1'b1;
         i_wr_data <= 16'($random(seed));
         ev <= st[6:3];
         stk = stk | (st[6:3] & {st[1], 3'h7});
         if (st[7]) begin
            i_link_ok <= 1'b0;
            lnk = 0;
         end
         repeat (3) @(posedge i_clk);
         ev <= 4'h0;
         go(st[10:8]);
         go(st[13:11]);
         rq(1'b1);
         i_link_ok <= 1'b1;
         i_wr_qs <= 1'b0;
         $display("test round done");
      end
      summarize();
   end
endmodule : phy_ident_and_quick_status_tb

// ==== piqs_hist.sv ====
`timescale 1ns/1ps
module piqs_hist
   import piqs_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // carrier
   piqs_hist_if.tracker hist
);
   logic [2:0] hi_q; // highest seen
   logic [2:0] hi_d;
   logic [2:0] lo_q; // lowest seen
   logic [2:0] lo_d;

   // track extremes; codes compare directly since priority is ascending
   always_comb begin
      hi_d = hi_q;
      lo_d = lo_q;
      if (hist.restart) begin
         // restart from the current state only
         hi_d = hist.cur_state;
         lo_d = hist.cur_state;
      end else begin
         if (hist.cur_state > hi_q) begin
            hi_d = hist.cur_state;
         end
         if (hist.cur_state < lo_q) begin
            lo_d = hist.cur_state;
         end
      end
   end

   // register the extremes
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hi_q <= PIQS_HI_RST;
         lo_q <= PIQS_LO_RST;
      end else begin
         hi_q <= hi_d;
         lo_q <= lo_d;
      end
   end

   assign hist.hi_state = hi_q;
   assign hist.lo_state = lo_q;
endmodule : piqs_hist

// ==== piqs_hist_if.sv ====
`timescale 1ns/1ps
// state history tracker carrier
interface piqs_hist_if;
   logic [2:0] cur_state; // current an state
   logic restart; // read restarts history
   logic [2:0] hi_state; // highest since read
   logic [2:0] lo_state; // lowest since read
   modport tracker (input cur_state, input restart, output hi_state, output lo_state);
   modport user (output cur_state, output restart, input hi_state, input lo_state);
endinterface : piqs_hist_if

// ==== piqs_host.sv ====
`timescale 1ns/1ps
// host side: request code to one read strobe
module piqs_host (
   // code: 1 id1, 2 id2, 3 status
   input wire logic [1:0] i_op,
   // strobes
   output logic o_rd_id1,
   output logic o_rd_id2,
   output logic o_rd_qs
);
   // one strobe at a time
   assign o_rd_id1 = i_op == 2'h1;
   assign o_rd_id2 = i_op == 2'h2;
   assign o_rd_qs = i_op == 2'h3;
endmodule : piqs_host

// ==== piqs_pkg.sv ====
package piqs_pkg;
   // register word width
   localparam int unsigned PIQS_W = 16;
   // identification field positions
   localparam int unsigned PIQS_REV_LSB = 0;
   localparam int unsigned PIQS_MODEL_LSB = 4;
   localparam int unsigned PIQS_OUI_LSB = 10;
   localparam int unsigned PIQS_OUI_W = 22;
   localparam int unsigned PIQS_OUI_TOP_W = 6;
   // quick-status field positions
   localparam int unsigned PIQS_HI_LSB = 0;
   localparam int unsigned PIQS_LO_LSB = 3;
   localparam int unsigned PIQS_DUPLEX_BIT = 8;
   localparam int unsigned PIQS_SPEED_BIT = 9;
   localparam int unsigned PIQS_PAUSE_BIT = 10;
   localparam int unsigned PIQS_LINK_BIT = 11;
   localparam int unsigned PIQS_JAB_BIT = 12;
   localparam int unsigned PIQS_RFLT_BIT = 13;
   localparam int unsigned PIQS_FCAR_BIT = 14;
   localparam int unsigned PIQS_RXER_BIT = 15;
   // auto-negotiation state codes in ascending priority
   localparam logic [2:0] PIQS_AN_ENABLED = 3'h0;
   localparam logic [2:0] PIQS_AN_ABILITY = 3'h1;
   localparam logic [2:0] PIQS_AN_LINK_CHECK = 3'h2;
   localparam logic [2:0] PIQS_AN_ACK_DETECT = 3'h3;
   localparam logic [2:0] PIQS_AN_COMPLETE_ACK = 3'h4;
   localparam logic [2:0] PIQS_AN_FLP_CHECK = 3'h5;
   localparam logic [2:0] PIQS_AN_NP_WAIT = 3'h6;
   localparam logic [2:0] PIQS_AN_FLP_GOOD = 3'h7;
   // reset values
   localparam logic [PIQS_W-1:0] PIQS_ZERO = 16'h0000;
   localparam logic [2:0] PIQS_HI_RST = 3'h0;
   localparam logic [2:0] PIQS_LO_RST = 3'h7;
   // read selects
   typedef enum logic [1:0] {
      PIQS_SEL_ID1,
      PIQS_SEL_ID2,
      PIQS_SEL_QS,
      PIQS_SEL_NONE
   } piqs_sel_e;
endpackage : piqs_pkg

// ==== piqs_top.sv ====
`timescale 1ns/1ps
module piqs_top
   import piqs_pkg::*;
#(
   // arbitrary neutral identity values
   parameter logic [PIQS_OUI_W-1:0] P_OUI = 22'h000000,
   parameter logic [5:0] P_MODEL = 6'h00,
   parameter logic [3:0] P_REV = 4'h0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // management register access, same clock domain
   input wire logic i_rd_id1,
   input wire logic i_rd_id2,
   input wire logic i_rd_qs,
   input wire logic i_wr_qs,
   input wire logic [PIQS_W-1:0] i_wr_data,
   // phy status pins, asynchronous
   input wire logic [2:0] i_an_state,
   input wire logic i_full_duplex,
   input wire logic i_speed_100,
   input wire logic i_pause_ok,
   input wire logic i_link_ok,
   input wire logic i_unlock_jabber,
   input wire logic i_remote_fault,
   input wire logic i_false_carrier,
   input wire logic i_rx_error,
   // read data
   output logic [PIQS_W-1:0] o_rd_data,
   output logic o_rd_valid
);
   localparam int unsigned NSYNC = 11; // synchronised pin count

   logic [NSYNC-1:0] s1_q; // first stage, read only by s2
   logic [NSYNC-1:0] s2_q; // second stage
   logic [NSYNC-1:0] s1_d; // pins as sampled
   logic [NSYNC-1:0] s2_d; // first stage forwarded
   logic [2:0] an_s; // synced state
   logic fdx_s; // synced full duplex
   logic spd_s; // synced 100 Mbps
   logic pau_s; // synced pause agreement
   logic lnk_s; // synced link level
   logic jab_s; // synced unlock or jabber event
   logic rf_s; // synced remote fault event
   logic fc_s; // synced false carrier event
   logic rxe_s; // synced receive error event
   logic link_q; // latching-low link
   logic link_d;
   logic jab_q; // sticky unlock or jabber
   logic jab_d;
   logic rf_q; // sticky remote fault
   logic rf_d;
   logic fc_q; // sticky false carrier
   logic fc_d;
   logic rxe_q; // sticky receive error
   logic rxe_d;
   logic [PIQS_W-1:0] data_q; // read data register
   logic [PIQS_W-1:0] data_d;
   logic vld_q; // answer strobe
   logic vld_d;
   logic [PIQS_W-1:0] id1_w; // id word one image
   logic [PIQS_W-1:0] id2_w; // id word two image
   logic [PIQS_W-1:0] qs_w; // quick-status image
   piqs_sel_e sel; // decoded read
   logic wr_ignored; // writes to quick status have no effect

   piqs_hist_if hist_c ();

   // two-flop synchroniser for every phy status pin; the status pins come from the
   // line side, so a level may change close to our edge
   always_comb begin
      // packing order must match the unpack below
      s1_d = {i_rx_error, i_false_carrier, i_remote_fault, i_unlock_jabber, i_link_ok,
              i_pause_ok, i_speed_100, i_full_duplex, i_an_state};
      // second stage only ever sees the first
      s2_d = s1_q;
   end

   // both stages clear on reset, so the link reads failed until pins arrive
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   // unpack synced pins; order mirrors the packing above
   // events stay as levels, the sticky logic below does the latching
   assign {rxe_s, fc_s, rf_s, jab_s, lnk_s, pau_s, spd_s, fdx_s, an_s} = s2_q;

   // history tracker, restarted by each quick-status read
   // the restart follows the strobe even when an id read wins the decode
   assign hist_c.cur_state = an_s;
   assign hist_c.restart = i_rd_qs;

   piqs_hist u_hist (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .hist(hist_c)
   );

   // identification words, constant
   // identity values are parameters, so the words fold to constants
   assign id1_w = P_OUI[PIQS_OUI_W-1:PIQS_OUI_TOP_W];
   assign id2_w = {P_OUI[PIQS_OUI_TOP_W-1:0], P_MODEL, P_REV};

   // quick-status image; bits six and seven fixed zero
   // hi and lo come from the tracker, flags from the sticky registers
   always_comb begin
      qs_w = PIQS_ZERO;
      qs_w[PIQS_HI_LSB +: 3] = hist_c.hi_state;
      qs_w[PIQS_LO_LSB +: 3] = hist_c.lo_state;
      qs_w[PIQS_DUPLEX_BIT] = fdx_s;
      qs_w[PIQS_SPEED_BIT] = spd_s;
      qs_w[PIQS_PAUSE_BIT] = pau_s;
      qs_w[PIQS_LINK_BIT] = link_q;
      qs_w[PIQS_JAB_BIT] = jab_q;
      qs_w[PIQS_RFLT_BIT] = rf_q;
      qs_w[PIQS_FCAR_BIT] = fc_q;
      qs_w[PIQS_RXER_BIT] = rxe_q;
   end

   // read decode, one select at a time, id1 first
   always_comb begin
      if (i_rd_id1) begin
         // id1 wins if the host strobes two at once
         sel = PIQS_SEL_ID1;
      end else if (i_rd_id2) begin
         sel = PIQS_SEL_ID2;
      end else if (i_rd_qs) begin
         // status only when no id read is asked for
         sel = PIQS_SEL_QS;
      end else begin
         // idle cycle, no answer
         sel = PIQS_SEL_NONE;
      end
   end

   // write data is deliberately dropped: the word is read only
   // nothing below reads this, it only marks where writes end up
   assign wr_ignored = i_wr_qs & (|i_wr_data);

   // flag next values; a new event wins over the read clear
   always_comb begin
      // link reloads current level on read, else latches low
      link_d = i_rd_qs ? lnk_s : (link_q & lnk_s);
      // sticky flags: set beats clear in the read cycle
      jab_d = jab_s | (jab_q & ~i_rd_qs);
      rf_d = rf_s | (rf_q & ~i_rd_qs);
      fc_d = fc_s | (fc_q & ~i_rd_qs);
      // receive error only counts at 100 Mbps; at 10 Mbps the pin is noise
      rxe_d = (rxe_s & spd_s) | (rxe_q & ~i_rd_qs);
   end

   // read answer next values
   always_comb begin
      // one answer strobe per request cycle
      vld_d = (sel != PIQS_SEL_NONE);
      unique case (sel)
         // identification words never change
         PIQS_SEL_ID1: data_d = id1_w;
         PIQS_SEL_ID2: data_d = id2_w;
         // snapshot taken before the read clear lands
         PIQS_SEL_QS: data_d = qs_w;
         // hold last word so a slow host can still pick it up
         PIQS_SEL_NONE: data_d = data_q;
      endcase
   end

   // flag registers; writes never reach them
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         // link starts failed, so the first read shows low
         link_q <= 1'b0;
         jab_q <= 1'b0;
         rf_q <= 1'b0;
         fc_q <= 1'b0;
         rxe_q <= 1'b0;
      end else begin
         link_q <= link_d;
         jab_q <= jab_d;
         rf_q <= rf_d;
         fc_q <= fc_d;
         rxe_q <= rxe_d;
      end
   end

   // read data registers; outputs come straight from these
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         data_q <= PIQS_ZERO;
         vld_q <= 1'b0;
      end else begin
         data_q <= data_d;
         vld_q <= vld_d;
      end
   end

   // registered outputs
   assign o_rd_data = data_q;
   assign o_rd_valid = vld_q;
endmodule : piqs_top

// ==== piqs_top_props.sv ====
`timescale 1ns/1ps
module piqs_top_props
   import piqs_pkg::*;
#(
   parameter logic [PIQS_OUI_W-1:0] P_OUI = 22'h000000,
   parameter logic [5:0] P_MODEL = 6'h00,
   parameter logic [3:0] P_REV = 4'h0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // register access strobes
   input wire logic i_rd_id1,
   input wire logic i_rd_id2,
   input wire logic i_rd_qs,
   input wire logic i_wr_qs,
   // status pins
   input wire logic [2:0] i_an_state,
   input wire logic i_full_duplex,
   input wire logic i_speed_100,
   input wire logic i_pause_ok,
   input wire logic i_link_ok,
   input wire logic i_unlock_jabber,
   input wire logic i_remote_fault,
   input wire logic i_false_carrier,
   input wire logic i_rx_error,
   // read answer
   input wire logic [PIQS_W-1:0] o_rd_data,
   input wire logic o_rd_valid
);
   logic qs; // status read alone
   logic [5:0] sv; // state and levels
   logic hot; // event or link loss
   assign qs = i_rd_qs && !i_rd_id1 && !i_rd_id2;
   assign sv = {i_an_state, i_pause_ok, i_speed_100, i_full_duplex};
   assign hot = i_unlock_jabber || i_remote_fault || i_false_carrier || i_rx_error || !i_link_ok;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // five-cycle windows cover the two sync flops
   AST_ID1: assert property (i_rd_id1 |=> o_rd_valid && o_rd_data == P_OUI[21:6])
      else $error("id1 bad");
   AST_ID2: assert property (i_rd_id2 && !i_rd_id1 |=> o_rd_data == {P_OUI[5:0], P_MODEL, P_REV})
      else $error("id2 bad");
   AST_Z67: assert property (qs |=> o_rd_valid && o_rd_data[7:6] == 2'h0)
      else $error("bits 7:6 set");
   AST_NOWR: assert property (!(i_rd_id1 || i_rd_id2 || i_rd_qs) |=> !o_rd_valid && $stable(o_rd_data))
      else $error("data moved");
   AST_STAT: assert property ($stable(sv)[*5] ##0 qs |=> o_rd_data[10:8] == $past(sv[2:0]))
      else $error("levels bad");
   AST_HIST: assert property ($stable(sv)[*5] ##0 qs ##1 qs |=> o_rd_data[5:0] == {2{$past(i_an_state, 2)}})
      else $error("history bad");
   AST_CLR: assert property ((!hot)[*5] ##0 qs ##1 qs |=> o_rd_data[15:11] == 5'h01)
      else $error("flags stuck");
   AST_LINK: assert property (qs && !$past(i_link_ok, 2) && !$past(i_link_ok, 3) && !$past(i_link_ok, 4)
      |=> !o_rd_data[11]) else $error("link not low");
   COV_B2B: cover property (qs ##1 qs);
   COV_ID: cover property (i_rd_id2 ##1 o_rd_valid);
   COV_WR: cover property (i_wr_qs && i_rd_qs);
endmodule : piqs_top_props

bind piqs_top piqs_top_props #(
   .P_OUI(P_OUI),
   .P_MODEL(P_MODEL),
   .P_REV(P_REV)
) props (
   .i_clk(i_clk),
   .i_sys_rst(i_sys_rst),
   .i_rd_id1(i_rd_id1),
   .i_rd_id2(i_rd_id2),
   .i_rd_qs(i_rd_qs),
   .i_wr_qs(i_wr_qs),
   .i_an_state(i_an_state),
   .i_full_duplex(i_full_duplex),
   .i_speed_100(i_speed_100),
   .i_pause_ok(i_pause_ok),
   .i_link_ok(i_link_ok),
   .i_unlock_jabber(i_unlock_jabber),
   .i_remote_fault(i_remote_fault),
   .i_false_carrier(i_false_carrier),
   .i_rx_error(i_rx_error),
   .o_rd_data(o_rd_data),
   .o_rd_valid(o_rd_valid)
);
